//--- verilog/network_command_executor.sv
// command execution and interrupt reporting of the network controller
`timescale 1ns/1ps
`include "netcmd_cfg.svh"

// Contract
// - no-op only posts completion status, interrupting if locally enabled.
// - send-data moves one local block to the named remote node's memory.
// - immediate request holds the transaction open until remote data arrives.
// - delayed request asks the remote to queue a return transaction.
// - delayed request completes locally once the remote accepts it.
// - returned delayed data shows original tags and the delayed type code.
// - local status copies statistics from byte zero, limited by byte count.
// - remote status fetches remote statistics like an immediate request.
// - send-no-op is only acknowledged remotely; local completion as usual.
// - reinitialise reruns init from buffer address, keeping statistics and tables.
// - self test writes a report to local memory, truncated to byte count.
// - polling-on needs master and loaded table; polling-off keeps the table.
// - polling table rejected unless byte count equals table length.
// - polling table refused in slave stations.
// - manual poll grants the node the network for at most slot time.
// - no new interrupt until host writes zero to the interrupt code.
// - pending interrupt bit readable whether or not interrupts are enabled.
// - queued completion posts code 02 with the slot reference.
// - interrupting receive fills fields, status 02, then code 01 and interrupt.
// - receive without interrupt request stores data, touches no status.
// - transaction status goes 01 in progress, 02 success, 03 error.
module network_command_executor
	import netcmd_pkg::*;
#(
	parameter logic [15:0] POLL_TABLE_LEN = `POLL_TBL_LEN
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// station strap
	input  wire logic                  master_strap,
	// network request and answer
	output logic                       net_req_valid,
	input  wire logic                  net_req_ready,
	output netcmd_pkg::net_req_t       net_req,
	input  wire logic                  net_resp_valid,
	input  wire logic [7:0]            net_resp_err,
	// received messages
	input  wire logic                  rx_valid,
	output logic                       rx_ready,
	input  wire netcmd_pkg::rx_msg_t   rx_msg,
	output logic                       mailbox_set,
	output logic [7:0]                 mailbox_num,
	// local memory writes
	output logic                       mem_valid,
	input  wire logic                  mem_ready,
	output logic [23:0]                mem_addr,
	output logic [7:0]                 mem_data,
	// polling and reinit
	output logic                       polling_on,
	output logic                       poll_grant,
	output logic [7:0]                 poll_node,
	input  wire logic                  poll_release,
	output logic                       reinit_valid,
	output logic [23:0]                reinit_addr,
	// hardware interrupt
	output logic                       irq
);
	typedef enum logic [2:0] {S_IDLE, S_DISPATCH, S_ISSUE, S_WAIT, S_COPY, S_GRANT, S_POST} state_t;

	state_t      state_q, state_d;
	logic [7:0]  cmd_q, slot_ref_q, xstat_q, err_q, icode_q, iref_q;
	logic [31:0] opt_q, tags_q, rxtag_q;
	logic [15:0] count_q, slot_time_q, grant_cnt_q, rxcnt_q;
	logic [23:0] lbuf_q, rbuf_q, rxaddr_q;
	logic [7:0]  rxstat_q, rxtype_q;
	logic        ien_q, irq_q, poll_q, tbl_ok_q;
	logic        m1_q, m2_q, m3_q, master_q;
	logic [15:0] ok_cnt_q, err_cnt_q, rx_cnt_q, cmd_cnt_q;
	logic [31:0] rdata_q;
	logic        mbox_q, reinit_q;
	logic [7:0]  mbox_num_q;
	logic [23:0] reinit_addr_q;
	logic        fin, copy_go, tbl_set, poll_set, poll_clr, reinit_go, copy_done;
	logic [7:0]  fin_err;
	logic [15:0] copy_idx;

	// apb decode
	wire wr       = psel && penable && pwrite;
	wire setup    = psel && !penable;
	wire hit_cmd  = paddr == `OFF_CMD;
	wire hit_opt  = paddr == `OFF_OPT;
	wire hit_cnt  = paddr == `OFF_COUNT;
	wire hit_lbuf = paddr == `OFF_LBUF;
	wire hit_rbuf = paddr == `OFF_RBUF;
	wire hit_tags = paddr == `OFF_TAGS;
	wire hit_go   = paddr == `OFF_GO;
	wire hit_xst  = paddr == `OFF_XSTAT;
	wire hit_ic   = paddr == `OFF_ICODE;
	wire hit_ctrl = paddr == `OFF_CTRL;
	wire hit_st   = paddr == `OFF_STATUS;
	wire hit_rxs  = paddr == `OFF_RXSTAT;
	wire hit_rxt  = paddr == `OFF_RXTAG;
	wire hit_rxa  = paddr == `OFF_RXADDR;
	wire hit_slot = paddr == `OFF_SLOT;
	wire mapped   = hit_cmd || hit_opt || hit_cnt || hit_lbuf || hit_rbuf || hit_tags || hit_go || hit_xst
		|| hit_ic || hit_ctrl || hit_st || hit_rxs || hit_rxt || hit_rxa || hit_slot;
	// parameter block writes are ignored while a command runs
	wire idle     = state_q == S_IDLE;
	wire pb_wr    = wr && idle;
	wire go       = pb_wr && hit_go;
	wire ic_clr   = wr && hit_ic && pwdata[7:0] == `IC_NONE;
	wire irq_clr  = wr && hit_ctrl && pwdata[`CTRL_CLR];

	wire lie      = opt_q[`OPT_LIE];
	wire link     = opt_q[`OPT_LINK];
	wire [7:0] node = opt_q[`OPT_NODE_LSB +: 8];

	wire [31:0] status_w = {27'h0, tbl_ok_q, poll_q, !idle, ien_q, irq_q};
	wire [31:0] rd_mux =
		hit_cmd  ? {24'h0, cmd_q} :
		hit_opt  ? opt_q :
		hit_cnt  ? {16'h0, count_q} :
		hit_lbuf ? {8'h0, lbuf_q} :
		hit_rbuf ? {8'h0, rbuf_q} :
		hit_tags ? tags_q :
		hit_go   ? {24'h0, slot_ref_q} :
		hit_xst  ? {16'h0, err_q, xstat_q} :
		hit_ic   ? {16'h0, iref_q, icode_q} :
		hit_ctrl ? {31'h0, ien_q} :
		hit_st   ? status_w :
		hit_rxs  ? {rxcnt_q, rxtype_q, rxstat_q} :
		hit_rxt  ? rxtag_q :
		hit_rxa  ? {8'h0, rxaddr_q} :
		hit_slot ? {16'h0, slot_time_q} : 32'h0;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = rdata_q;

	always_ff @(posedge clk) begin
		if (srst)
			rdata_q <= 32'h0;
		else if (setup)
			rdata_q <= rd_mux;
	end

	// parameter block registers
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_q       <= `CMD_NOP;
			opt_q       <= 32'h0;
			count_q     <= 16'h0;
			lbuf_q      <= 24'h0;
			rbuf_q      <= 24'h0;
			tags_q      <= 32'h0;
			slot_ref_q  <= 8'h0;
			slot_time_q <= 16'h0;
			ien_q       <= 1'b0;
		end else begin
			if (pb_wr && hit_cmd)  cmd_q <= pwdata[7:0];
			if (pb_wr && hit_opt)  opt_q <= pwdata;
			if (pb_wr && hit_cnt)  count_q <= pwdata[15:0];
			if (pb_wr && hit_lbuf) lbuf_q <= pwdata[23:0];
			if (pb_wr && hit_rbuf) rbuf_q <= pwdata[23:0];
			if (pb_wr && hit_tags) tags_q <= pwdata;
			if (pb_wr && hit_slot) slot_time_q <= pwdata[15:0];
			if (go)                slot_ref_q <= pwdata[7:0];
			if (wr && hit_ctrl)    ien_q <= pwdata[`CTRL_IEN];
		end
	end

	// strap sync; a change counts once the last two stages agree
	always_ff @(posedge clk) begin
		if (srst) begin
			m1_q     <= 1'b0;
			m2_q     <= 1'b0;
			m3_q     <= 1'b0;
			master_q <= 1'b0;
		end else begin
			m1_q <= master_strap;
			m2_q <= m1_q;
			m3_q <= m2_q;
			if (m2_q == m3_q)
				master_q <= m3_q;
		end
	end

	// command dispatch
	always_comb begin
		state_d   = state_q;
		fin       = 1'b0;
		fin_err   = `ERR_NONE;
		copy_go   = 1'b0;
		tbl_set   = 1'b0;
		poll_set  = 1'b0;
		poll_clr  = 1'b0;
		reinit_go = 1'b0;
		case (state_q)
			S_IDLE: if (go) state_d = S_DISPATCH;
			S_DISPATCH: begin
				case (cmd_q)
					`CMD_NOP: fin = 1'b1;
					`CMD_REINIT: begin
						reinit_go = 1'b1;
						fin       = 1'b1;
					end
					`CMD_SELFTEST, `CMD_LOC_STAT: begin
						copy_go = 1'b1;
						state_d = S_COPY;
					end
					`CMD_POLL_ON: begin
						fin = 1'b1;
						if (master_q && tbl_ok_q) poll_set = 1'b1;
						else fin_err = `ERR_PARAM;
					end
					`CMD_POLL_OFF: begin
						fin      = 1'b1;
						poll_clr = 1'b1;
					end
					`CMD_SET_TABLE: begin
						fin = 1'b1;
						if (master_q && count_q == POLL_TABLE_LEN) tbl_set = 1'b1;
						else fin_err = `ERR_PARAM;
					end
					`CMD_POLL: begin
						if (tbl_ok_q) state_d = S_GRANT;
						else begin
							fin     = 1'b1;
							fin_err = `ERR_PARAM;
						end
					end
					`CMD_SEND, `CMD_SEND_NOP, `CMD_REQ_IMM, `CMD_REQ_DLY, `CMD_REM_STAT: state_d = S_ISSUE;
					default: begin
						fin     = 1'b1;
						fin_err = `ERR_PARAM;
					end
				endcase
			end
			S_ISSUE: if (net_req_ready) state_d = S_WAIT;
			// immediate and remote-status answers carry the data; delayed answers only accept
			S_WAIT: begin
				fin     = net_resp_valid;
				fin_err = net_resp_valid ? net_resp_err : `ERR_NONE;
			end
			S_COPY: fin = copy_done;
			S_GRANT: fin = poll_release || grant_cnt_q <= 16'h0001;
			S_POST: if (icode_q == `IC_NONE) state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
		// linked blocks complete silently; the chain's last block reports
		if (fin)
			state_d = (lie && !link) ? S_POST : S_IDLE;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q     <= S_IDLE;
			xstat_q     <= `XS_IDLE;
			err_q       <= `ERR_NONE;
			grant_cnt_q <= 16'h0;
		end else begin
			state_q <= state_d;
			if (go)
				xstat_q <= `XS_BUSY;
			else if (fin) begin
				xstat_q <= (fin_err == `ERR_NONE) ? `XS_OK : `XS_ERR;
				err_q   <= fin_err;
			end
			if (state_q == S_DISPATCH)
				grant_cnt_q <= slot_time_q;
			else if (state_q == S_GRANT)
				grant_cnt_q <= grant_cnt_q - 16'h0001;
		end
	end

	// polling state and statistics survive reinitialise
	always_ff @(posedge clk) begin
		if (srst) begin
			poll_q    <= 1'b0;
			tbl_ok_q  <= 1'b0;
			ok_cnt_q  <= 16'h0;
			err_cnt_q <= 16'h0;
			cmd_cnt_q <= 16'h0;
		end else begin
			if (poll_set) poll_q <= 1'b1;
			else if (poll_clr) poll_q <= 1'b0;
			if (tbl_set) tbl_ok_q <= 1'b1;
			if (go) cmd_cnt_q <= cmd_cnt_q + 16'h0001;
			if (fin && fin_err == `ERR_NONE) ok_cnt_q <= ok_cnt_q + 16'h0001;
			if (fin && fin_err != `ERR_NONE) err_cnt_q <= err_cnt_q + 16'h0001;
		end
	end

	// local copies of the statistics table or self-test report
	// the copier's length is clipped here, so it never reads past either table
	wire  [15:0] src_len  = (cmd_q == `CMD_SELFTEST) ? `SELFTEST_LEN : `STAT_LEN;
	wire  [15:0] copy_len = (count_q < src_len) ? count_q : src_len;
	wire  [63:0] stats    = {cmd_cnt_q, rx_cnt_q, err_cnt_q, ok_cnt_q};

	byte_copier #(.AW(24), .CW(16)) copier (
		.clk   (clk),
		.srst  (srst),
		.start (copy_go),
		.base  (lbuf_q),
		.len   (copy_len),
		.valid (mem_valid),
		.ready (mem_ready),
		.addr  (mem_addr),
		.idx   (copy_idx),
		.done  (copy_done)
	);
	// statistics always start at byte zero
	assign mem_data = (cmd_q == `CMD_SELFTEST) ? `SELFTEST_PASS : stats[{copy_idx[2:0], 3'b000} +: 8];

	// network request from the parameter block
	assign net_req_valid = state_q == S_ISSUE;
	assign net_req       = '{cmd: cmd_q, node: node, count: count_q, lbuf: lbuf_q, rbuf: rbuf_q, tags: tags_q,
		mailbox: opt_q[`OPT_MBOX_LSB +: 8], mm: opt_q[`OPT_MM], rie: opt_q[`OPT_RIE]};

	assign poll_grant   = state_q == S_GRANT;
	assign poll_node    = node;
	assign polling_on   = poll_q;
	assign reinit_valid = reinit_q;
	assign reinit_addr  = reinit_addr_q;

	// receive path; one interrupting message waits while the code is held
	wire post_done = state_q == S_POST && icode_q == `IC_NONE;
	assign rx_ready = !rx_msg.rie || (icode_q == `IC_NONE && state_q != S_POST);
	wire rx_take = rx_valid && rx_ready;
	wire post_rx = rx_take && rx_msg.rie;

	always_ff @(posedge clk) begin
		if (srst) begin
			rxstat_q <= `RXS_NONE;
			rxtype_q <= 8'h0;
			rxtag_q  <= 32'h0;
			rxcnt_q  <= 16'h0;
			rxaddr_q <= 24'h0;
			rx_cnt_q <= 16'h0;
		end else begin
			if (rx_take) rx_cnt_q <= rx_cnt_q + 16'h0001;
			if (post_rx) begin
				rxstat_q <= `RXS_DONE;
				rxtype_q <= rx_msg.ret_dly ? `RX_TYPE_DLY : rx_msg.rtype;
				rxtag_q  <= rx_msg.tags;
				rxcnt_q  <= rx_msg.count;
				rxaddr_q <= rx_msg.addr;
			end
		end
	end

	// interrupt code and hardware interrupt; a post beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			icode_q       <= `IC_NONE;
			iref_q        <= 8'h0;
			irq_q         <= 1'b0;
			mbox_q        <= 1'b0;
			mbox_num_q    <= 8'h0;
			reinit_q      <= 1'b0;
			reinit_addr_q <= 24'h0;
		end else begin
			if (post_rx) begin
				icode_q <= `IC_RX;
				iref_q  <= 8'h0;
			end else if (post_done) begin
				icode_q <= `IC_DONE;
				iref_q  <= slot_ref_q;
			end else if (ic_clr)
				icode_q <= `IC_NONE;
			if (post_rx || post_done)
				irq_q <= 1'b1;
			else if (irq_clr)
				irq_q <= 1'b0;
			mbox_q     <= rx_take;
			mbox_num_q <= rx_msg.mailbox;
			reinit_q   <= reinit_go;
			if (reinit_go) reinit_addr_q <= lbuf_q;
		end
	end

	assign irq         = irq_q && ien_q;
	assign mailbox_set = mbox_q;
	assign mailbox_num = mbox_num_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	icode_held_a: assert property ((icode_q != `IC_NONE && !ic_clr) |=> icode_q == $past(icode_q))
		else $error("interrupt code changed while held");
	status_busy_a: assert property (go |=> xstat_q == `XS_BUSY)
		else $error("transaction status not in progress after start");
	nop_done_a: assert property ((go && cmd_q == `CMD_NOP) |=> ##1 xstat_q == `XS_OK)
		else $error("no-op did not complete");
	rx_silent_a: assert property ((rx_take && !rx_msg.rie && !post_done) |=> rxstat_q == $past(rxstat_q) && !$rose(irq_q))
		else $error("silent receive touched status");
	rx_post_a: assert property (post_rx |=> icode_q == `IC_RX && rxstat_q == `RXS_DONE && irq_q)
		else $error("receive interrupt not posted");
	done_post_a: assert property (post_done |=> icode_q == `IC_DONE && iref_q == $past(slot_ref_q))
		else $error("completion code or reference wrong");
	poll_gate_a: assert property ($rose(poll_q) |-> $past(master_q && tbl_ok_q))
		else $error("polling enabled without master and table");
	table_len_a: assert property ($rose(tbl_ok_q) |-> $past(count_q == POLL_TABLE_LEN && master_q))
		else $error("polling table accepted with bad length");
	copy_limit_a: assert property (mem_valid |-> copy_idx < count_q && copy_idx < src_len)
		else $error("copy ran past its limit");
	pend_bit_a: assert property ((post_rx || post_done) |=> status_w[`ST_PEND])
		else $error("pending bit not shown");

	nop_cover_c: cover property (go && cmd_q == `CMD_NOP ##2 state_q == S_POST);
	rx_cover_c: cover property (post_rx ##[1:20] ic_clr);
	copy_cover_c: cover property (mem_valid && mem_ready ##1 copy_done);
	grant_cover_c: cover property (poll_grant ##1 !poll_grant);
endmodule

//--- shared/netcmd_cfg.svh
// constants for the network command executor: offsets, fields, codes, table lengths
`ifndef NETCMD_CFG_SVH
`define NETCMD_CFG_SVH

// register byte offsets
`define OFF_CMD        8'h00
`define OFF_OPT        8'h04
`define OFF_COUNT      8'h08
`define OFF_LBUF       8'h0C
`define OFF_RBUF       8'h10
`define OFF_TAGS       8'h14
`define OFF_GO         8'h18
`define OFF_XSTAT      8'h1C
`define OFF_ICODE      8'h20
`define OFF_CTRL       8'h24
`define OFF_STATUS     8'h28
`define OFF_RXSTAT     8'h2C
`define OFF_RXTAG      8'h30
`define OFF_RXADDR     8'h34
`define OFF_SLOT       8'h38

// option register fields
`define OPT_LIE        0
`define OPT_RIE        1
`define OPT_MM         2
`define OPT_LINK       3
`define OPT_MBOX_LSB   8
`define OPT_NODE_LSB   16

// control and status register fields
`define CTRL_IEN       0
`define CTRL_CLR       1
`define ST_PEND        0
`define ST_IEN         1
`define ST_BUSY        2
`define ST_POLL        3
`define ST_TABLE       4

// command codes
`define CMD_NOP        8'h00
`define CMD_REINIT     8'h01
`define CMD_SELFTEST   8'h02
`define CMD_POLL_ON    8'h03
`define CMD_POLL_OFF   8'h04
`define CMD_SET_TABLE  8'h05
`define CMD_POLL       8'h06
`define CMD_SEND       8'h07
`define CMD_SEND_NOP   8'h08
`define CMD_REQ_IMM    8'h09
`define CMD_REQ_DLY    8'h0A
`define CMD_LOC_STAT   8'h0B
`define CMD_REM_STAT   8'h0C

// status, interrupt and error codes
`define XS_IDLE        8'h00
`define XS_BUSY        8'h01
`define XS_OK          8'h02
`define XS_ERR         8'h03
`define IC_NONE        8'h00
`define IC_RX          8'h01
`define IC_DONE        8'h02
`define RXS_NONE       8'h00
`define RXS_DONE       8'h02
`define RX_TYPE_DLY    8'h82
`define ERR_NONE       8'h00
`define ERR_PARAM      8'h01
`define SELFTEST_PASS  8'h00

// table lengths in bytes
`define STAT_LEN       16'h0008
`define SELFTEST_LEN   16'h0008
`define POLL_TBL_LEN   16'h0010

`endif

//--- shared/netcmd_pkg.sv
// types shared by the network command executor and its bench
package netcmd_pkg;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [7:0]  node;
		logic [15:0] count;
		logic [23:0] lbuf;
		logic [23:0] rbuf;
		logic [31:0] tags;
		logic [7:0]  mailbox;
		logic        mm;
		logic        rie;
	} net_req_t;

	typedef struct packed {
		logic [7:0]  rtype;
		logic        ret_dly;
		logic [31:0] tags;
		logic [15:0] count;
		logic [23:0] addr;
		logic [7:0]  mailbox;
		logic        rie;
	} rx_msg_t;
endpackage

//--- verilog/byte_copier.sv
// walks a byte index over a local buffer with valid/ready back-pressure
`timescale 1ns/1ps
module byte_copier #(
	parameter int AW = 24,
	parameter int CW = 16
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          srst,
	// request
	input  wire logic          start,
	input  wire logic [AW-1:0] base,
	input  wire logic [CW-1:0] len,
	// byte stream out
	output logic               valid,
	input  wire logic          ready,
	output logic [AW-1:0]      addr,
	output logic [CW-1:0]      idx,
	output logic               done
);
	logic          active_q;
	logic [CW-1:0] idx_q;
	logic [CW-1:0] len_q;
	logic [AW-1:0] base_q;
	logic          done_q;
	wire           last = (idx_q + 1'b1) == len_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			active_q <= 1'b0;
			idx_q    <= '0;
			len_q    <= '0;
			base_q   <= '0;
			done_q   <= 1'b0;
		end else if (start) begin
			active_q <= len != '0;
			done_q   <= len == '0;
			idx_q    <= '0;
			len_q    <= len;
			base_q   <= base;
		end else if (active_q && ready) begin
			idx_q    <= idx_q + 1'b1;
			active_q <= !last;
			done_q   <= last;
		end else begin
			done_q   <= 1'b0;
		end
	end

	assign valid = active_q;
	assign idx   = idx_q;
	assign addr  = base_q + AW'(idx_q);
	assign done  = done_q;
endmodule

//--- verification/net_partner.sv
// remote node model: takes a request, then answers it
`timescale 1ns/1ps
module net_partner (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 srst,
	// answer delay and error code
	input  wire logic [3:0]           lat,
	input  wire logic [7:0]           err,
	// request and answer
	input  wire logic                 net_req_valid,
	output logic                      net_req_ready,
	input  wire netcmd_pkg::net_req_t net_req,
	output logic                      net_resp_valid,
	output logic [7:0]                net_resp_err
);
	import netcmd_pkg::*;
	logic [3:0] cnt_q;
	logic       wait_q;
	// code line shows garbage outside the answer pulse
	assign net_resp_err = net_resp_valid ? err : ~err;
	always_ff @(posedge clk) begin
		net_req_ready <= 1'b0;
		net_resp_valid <= 1'b0;
		if (srst) begin
			cnt_q <= 4'h0;
			wait_q <= 1'b0;
		end else if (!wait_q && net_req_valid && !net_req_ready) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == lat) begin
				net_req_ready <= 1'b1;
				cnt_q <= 4'h0;
				wait_q <= 1'b1;
			end
		end else if (wait_q) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == lat) begin
				net_resp_valid <= 1'b1;
				cnt_q <= 4'h0;
				wait_q <= 1'b0;
			end
		end
	end
endmodule

//--- verification/tb_top.sv
// self-checking bench of the network command executor
`timescale 1ns/1ps
`include "netcmd_cfg.svh"
module tb_top;
	import netcmd_pkg::*;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr, er;
	logic        net_req_valid, net_req_ready, net_resp_valid, rx_valid, rx_ready;
	logic        mailbox_set, mem_valid, mem_ready, polling_on, poll_grant;
	logic        master_strap, poll_release, reinit_valid, irq;
	logic [7:0]  paddr, net_resp_err, mailbox_num, mem_data, poll_node, err, rq_cmd, md, pn;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] mem_addr, reinit_addr, ra, ma;
	logic [3:0]  lat;
	net_req_t    net_req;
	rx_msg_t     rx_msg;
	int          mismatches, cmp_count, nmem, ngr, nmb;
	logic [7:0]  rem [5] = '{`CMD_SEND, `CMD_SEND_NOP, `CMD_REQ_IMM, `CMD_REQ_DLY, `CMD_REM_STAT};

	network_command_executor #(.POLL_TABLE_LEN(16'h0010)) i_dut (.clk, .srst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .master_strap, .net_req_valid, .net_req_ready,
		.net_req, .net_resp_valid, .net_resp_err, .rx_valid, .rx_ready, .rx_msg, .mailbox_set,
		.mailbox_num, .mem_valid, .mem_ready, .mem_addr, .mem_data, .polling_on, .poll_grant,
		.poll_node, .poll_release, .reinit_valid, .reinit_addr, .irq);
	net_partner i_far (.clk, .srst, .lat, .err, .net_req_valid, .net_req_ready, .net_req,
		.net_resp_valid, .net_resp_err);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		if (mem_valid && mem_ready) begin
			nmem++;
			ma = mem_addr;
			md = mem_data;
		end
		if (poll_grant) begin
			ngr++;
			pn = poll_node;
		end
		if (mailbox_set) nmb++;
		if (reinit_valid) ra = reinit_addr;
		if (net_req_valid && net_req_ready) rq_cmd = net_req.cmd;
		mem_ready <= ~mem_ready;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (!pready) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle cycle, so a following call never re-raises psel in this time step
		@(posedge clk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask

	task automatic run(input logic [7:0] c, input logic [31:0] o, input logic [15:0] n);
		apb(1'b1, `OFF_CMD, {24'h0, c});
		apb(1'b1, `OFF_OPT, o);
		apb(1'b1, `OFF_COUNT, {16'h0, n});
		apb(1'b1, `OFF_GO, 32'h5);
		repeat (2) @(posedge clk);
		rd = 32'h4;
		for (int i = 0; i < 200 && rd[`ST_BUSY]; i++) apb(1'b0, `OFF_STATUS, 32'h0);
	endtask

	task automatic rxm(input logic r, input logic e);
		rx_msg <= {8'h07, r, 32'hA5A50000 | {30'h0, r, e}, 16'h0010, 24'h000200, 8'h03, e};
		rx_valid <= 1'b1;
		@(posedge clk);
		while (!rx_ready) @(posedge clk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, rx_valid, rx_msg, poll_release, mem_ready} = '0;
		{mismatches, cmp_count, nmem, ngr, nmb} = '0;
		srst = 1'b1;
		master_strap = 1'b1;
		lat = 4'h2;
		err = 8'h00;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		rc(`OFF_STATUS, 32'h0, "status reset");
		apb(1'b0, 8'hFC, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, `OFF_LBUF, 32'h100);
		run(`CMD_NOP, 32'h1, 16'h0);
		rc(`OFF_XSTAT, 32'h2, "nop status");
		rc(`OFF_ICODE, 32'h0502, "nop code");
		rc(`OFF_STATUS, 32'h1, "pending");
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `OFF_CTRL, 32'h1);
		#1 chk("irq on", 32'h1, {31'h0, irq});
		run(`CMD_NOP, 32'h1, 16'h0);
		apb(1'b1, `OFF_ICODE, 32'h1);
		rc(`OFF_ICODE, 32'h0502, "code held");
		apb(1'b1, `OFF_CTRL, 32'h3);
		apb(1'b1, `OFF_ICODE, 32'h0);
		repeat (3) @(posedge clk);
		rc(`OFF_ICODE, 32'h0502, "next post");
		#1 chk("irq again", 32'h1, {31'h0, irq});
		apb(1'b1, `OFF_CTRL, 32'h2);
		apb(1'b1, `OFF_ICODE, 32'h0);
		apb(1'b1, `OFF_CTRL, 32'h0);
		rc(`OFF_STATUS, 32'h0, "pending clear");
		foreach (rem[i]) begin
			run(rem[i], 32'h0, 16'h4);
			chk("remote cmd", {24'h0, rem[i]}, {24'h0, rq_cmd});
			rc(`OFF_XSTAT, 32'h2, "remote status");
		end
		lat <= 4'h5;
		err <= 8'h21;
		run(`CMD_SEND, 32'h0, 16'h4);
		rc(`OFF_XSTAT, 32'h2103, "remote error");
		err <= 8'h00;
		nmem = 0;
		run(`CMD_LOC_STAT, 32'h0, 16'h3);
		chk("stat bytes", 32'h3, nmem);
		chk("stat last addr", 32'h102, {8'h0, ma});
		chk("stat last byte", 32'h1, {24'h0, md});
		nmem = 0;
		run(`CMD_SELFTEST, 32'h0, 16'h20);
		chk("test bytes", 32'h8, nmem);
		chk("test last addr", 32'h107, {8'h0, ma});
		run(`CMD_REINIT, 32'h0, 16'h0);
		chk("reinit addr", 32'h100, {8'h0, ra});
		run(`CMD_POLL_ON, 32'h0, 16'h0);
		rc(`OFF_XSTAT, 32'h0103, "poll early");
		run(`CMD_SET_TABLE, 32'h0, 16'h000F);
		rc(`OFF_XSTAT, 32'h0103, "table len");
		run(`CMD_SET_TABLE, 32'h0, 16'h0010);
		run(`CMD_POLL_ON, 32'h0, 16'h0);
		#1 chk("polling on", 32'h1, {31'h0, polling_on});
		run(`CMD_POLL_OFF, 32'h0, 16'h0);
		rc(`OFF_STATUS, 32'h10, "table kept");
		apb(1'b1, `OFF_SLOT, 32'h4);
		ngr = 0;
		run(`CMD_POLL, 32'h00090000, 16'h0);
		repeat (8) @(posedge clk);
		chk("grant span", 32'h4, ngr);
		chk("poll node", 32'h9, {24'h0, pn});
		rxm(1'b0, 1'b1);
		rc(`OFF_RXSTAT, 32'h00100702, "rx status");
		rc(`OFF_ICODE, 32'h1, "rx code");
		rxm(1'b1, 1'b0);
		rc(`OFF_RXTAG, 32'hA5A50001, "rx quiet");
		rc(`OFF_RXSTAT, 32'h00100702, "rx untouched");
		apb(1'b1, `OFF_CTRL, 32'h2);
		apb(1'b1, `OFF_ICODE, 32'h0);
		rxm(1'b1, 1'b1);
		rc(`OFF_RXSTAT, 32'h00108202, "return type");
		rc(`OFF_RXTAG, 32'hA5A50003, "return tags");
		chk("mailbox", 32'h3, nmb);
		chk("mailbox num", 32'h3, {24'h0, mailbox_num});
		master_strap <= 1'b0;
		repeat (6) @(posedge clk);
		run(`CMD_SET_TABLE, 32'h0, 16'h0010);
		rc(`OFF_XSTAT, 32'h0103, "slave table");
		results();
	end
endmodule
